//--- hdl/ulm_pkg.sv
// constants, types and format helpers for the uart line/modem channel
`default_nettype none
package ulm_pkg;
  // ===================================================================
  // register byte offsets
  localparam logic [4:0] ADR_DATA = 5'h00;
  localparam logic [4:0] ADR_IER = 5'h04;
  localparam logic [4:0] ADR_LCR = 5'h08;
  localparam logic [4:0] ADR_MCR = 5'h0c;
  localparam logic [4:0] ADR_LSR = 5'h10;
  localparam logic [4:0] ADR_MSR = 5'h14;
  localparam logic [4:0] ADR_EFR = 5'h18;
  localparam logic [4:0] ADR_DIV = 5'h1c;
  // ===================================================================
  // field positions
  localparam int LCR_STB = 2;
  localparam int LCR_PEN = 3;
  localparam int LCR_EPS = 4;
  localparam int LCR_STICK = 5;
  localparam int LCR_BRK = 6;
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_SEL = 2;
  localparam int MCR_IMM = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_XANY = 5;
  localparam int MCR_IR = 6;
  localparam int MCR_PRE = 7;
  localparam int EFR_SWF = 3;
  localparam int EFR_ENH = 4;
  localparam int EFR_AUTO = 6;
  localparam int IER_LS = 2;
  localparam int MSR_TXDIS = 3;
  // ===================================================================
  // reset values and codes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // ===================================================================
  // timing in 16x sample ticks; PRE_LAST counts core clocks
  localparam logic [4:0] BIT_LAST = 5'h0f;
  localparam logic [3:0] RBIT_LAST = 4'hf;
  localparam logic [3:0] MID_LAST = 4'h7;
  localparam logic [4:0] STOP1_LAST = 5'h0f;
  localparam logic [4:0] STOP15_LAST = 5'h17;
  localparam logic [4:0] STOP2_LAST = 5'h1f;
  localparam logic [4:0] IR_PULSE = 5'h03;
  localparam logic [3:0] IR_HOLD = 4'hf;
  localparam logic [1:0] PRE_LAST = 2'h3;
  // ===================================================================
  // types
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
    TX_PAR = 3'b011, TX_STOP = 3'b100
  } ulm_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PAR = 3'b011, RX_STOP = 3'b100
  } ulm_rx_st_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } ulm_avm_req_t;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } ulm_avm_rsp_t;
  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } ulm_modem_in_t;
  typedef struct packed {
    logic rts_n;
    logic dtr_n;
  } ulm_modem_out_t;
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] d;
  } ulm_rx_ent_t;
  // ===================================================================
  // format helpers
  function automatic logic [7:0] wmask(input logic [7:0] l);
    wmask = 8'hff >> (2'h3 - l[1:0]);
  endfunction : wmask
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [7:0] l);
    par_bit = l[LCR_STICK] ? ~l[LCR_EPS]
                           : ~(^(d & wmask(l))) ^ l[LCR_EPS];
  endfunction : par_bit
  function automatic logic [4:0] stop_last(input logic [7:0] l);
    if (!l[LCR_STB]) stop_last = STOP1_LAST;
    else if (l[1:0] == 2'h0) stop_last = STOP15_LAST;
    else stop_last = STOP2_LAST;
  endfunction : stop_last
endpackage : ulm_pkg
`default_nettype wire

//--- hdl/ulm_top.sv
// uart channel: line format, modem control, line status, avalon slave
// What this block does
// - parity-type bit picks odd (0) or even (1) parity, both directions
// - parity-enable adds a transmit parity bit and a receive check
// - stop bit: one, or 1.5 for 5-bit and 2 for longer words
// - word-length bits give 5, 6, 7 or 8 data bits
// - prescaler bit, enhanced-gated, divides baud clock by one or four
// - infrared bit loads strap after reset; encoder idles tx low
// - xon-any makes any received non-break character except xoff resume stopped transmission
// - loopback bit routes the channel internally
// - send-immediate byte goes before queued bytes; bit self-clears on the data write, except in loopback
// - send-immediate needs transmitter enabled; flow characters go first
// - in loopback immediate and select bits drive carrier and ring
// - select bit picks rts/cts or dtr/dsr pair under auto flow
// - outside loopback and the auto-flow pair, rts and dtr bits drive pins low when set, high when clear
// - line-status interrupt when enabled and any queued error exists
// - error summary set while any error character remains queued
// - transmitter-empty only when queue and shifter both empty
// - holding-empty sets on last byte moved, clears on write
// - a full low frame loads one break character, held till rx high
// - framing and parity flags follow the character at the head
// - character into a full queue sets overrun and is dropped
// - data-ready while any received character is held
// - forced parity is 1 for parity-type 0, 0 for type 1
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ulm_top import ulm_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire ulm_avm_req_t avm_i,
  output var ulm_avm_rsp_t avm_o,
  input wire logic rx_i,
  output var logic tx_o,
  input wire ulm_modem_in_t modem_i,
  output var ulm_modem_out_t modem_o,
  input wire logic ir_strap_i,
  output var logic line_irq_o
);
  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] ulm_cnt_t;
  typedef logic [AW-1:0] ulm_ptr_t;
  localparam ulm_cnt_t FULL = ulm_cnt_t'(DEPTH);
  localparam ulm_cnt_t HIGH = ulm_cnt_t'(DEPTH - 1);

  // =================================================================
  // state
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic [7:0] interrupt_enable_reg, line_format_control, modem_pin_control, enhanced_feature_reg;
    logic txdis;
    logic [15:0] div;
    logic strap_done;
    logic [1:0] pre;
    logic [15:0] bcnt;
    logic [DEPTH-1:0][7:0] tq;
    ulm_ptr_t tw, tr;
    ulm_cnt_t tn;
    logic imm_v;
    logic [7:0] imm;
    logic fl_v;
    logic [7:0] fl;
    logic xoff_rx, xoff_sent;
    ulm_tx_st_t ts;
    logic [4:0] tt;
    logic [2:0] tb;
    logic [7:0] tsh, tdat;
    logic tpar, tline, txo;
    ulm_rx_ent_t [DEPTH-1:0] rq;
    ulm_ptr_t rw, rr;
    ulm_cnt_t rn, errn;
    logic ovr;
    ulm_rx_st_t rs;
    logic [3:0] rt;
    logic [2:0] rb;
    logic [7:0] rsh;
    logic rpar, rz, brk_act;
    logic [3:0] irc;
    logic rts_n, dtr_n;
  } ulm_state_t;

  ulm_state_t s_reg, s_next;

  // =================================================================
  // decode
  logic req, acc, loop, ir_on, bclk, tick, txl, rxd, hw_stop, af;
  logic thre, temt, tld, rdone, rpush, rpop, tpush, tpop;
  logic [7:0] tbyte, line_status_flags, modem_input_status, rdat;
  logic [2:0] wlast;
  ulm_rx_ent_t top, rent;

  assign req = avm_i.read | avm_i.write;
  assign acc = req & s_reg.ack;
  assign loop = s_reg.modem_pin_control[MCR_LOOP];
  assign ir_on = s_reg.modem_pin_control[MCR_IR];
  assign wlast = {1'b1, s_reg.line_format_control[1:0]};
  // prescale stretches the baud input clock by four
  assign bclk = ~s_reg.modem_pin_control[MCR_PRE] | (s_reg.pre == PRE_LAST);
  assign tick = bclk & (s_reg.bcnt + 16'h1 >= s_reg.div);
  assign txl = s_reg.tline & ~s_reg.line_format_control[LCR_BRK];
  // ir receive: a high pulse marks a zero bit, stretched over the bit
  assign rxd = loop ? txl
             : (ir_on ? ~(rx_i | (s_reg.irc != 4'h0)) : rx_i);
  assign af = s_reg.enhanced_feature_reg[EFR_AUTO] & ~loop;
  assign hw_stop = af & (s_reg.modem_pin_control[MCR_SEL] ? modem_i.dsr_n
                                           : modem_i.cts_n);
  assign top = s_reg.rq[s_reg.rr];
  assign rdat = s_reg.rsh >> (2'h3 - s_reg.line_format_control[1:0]);
  assign thre = (s_reg.tn == '0) & ~s_reg.imm_v;
  assign temt = thre & ~s_reg.fl_v & (s_reg.ts == TX_IDLE);
  assign line_status_flags = {s_reg.errn != '0, temt, thre,
                (s_reg.rn != '0 & top.brk) | s_reg.brk_act,
                s_reg.rn != '0 & top.fe, s_reg.rn != '0 & top.pe,
                s_reg.ovr, s_reg.rn != '0};
  assign modem_input_status = loop ? {s_reg.modem_pin_control[MCR_IMM], s_reg.modem_pin_control[MCR_SEL],
                       s_reg.modem_pin_control[MCR_DTR], s_reg.modem_pin_control[MCR_RTS],
                       s_reg.txdis, 3'h0}
                    : {~modem_i.cd_n, ~modem_i.ri_n, ~modem_i.dsr_n,
                       ~modem_i.cts_n, s_reg.txdis, 3'h0};

  assign avm_o.waitrequest = req & ~s_reg.ack;
  assign avm_o.readdata = {16'h0, s_reg.rdata};
  assign tx_o = s_reg.txo;
  assign modem_o.rts_n = s_reg.rts_n;
  assign modem_o.dtr_n = s_reg.dtr_n;
  assign line_irq_o = s_reg.interrupt_enable_reg[IER_LS] & (line_status_flags[7] | s_reg.ovr);

  // =================================================================
  // next state
  always_comb begin
    s_next = s_reg;
    tld = 1'b0;
    tbyte = 8'h0;
    rdone = 1'b0;
    rpush = 1'b0;
    rpop = 1'b0;
    tpush = 1'b0;
    tpop = 1'b0;
    rent = '0;
    // strap is caught on the first edge after reset release
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.modem_pin_control[MCR_IR] = ir_strap_i;
    end
    // one wait cycle: read data is latched before the answer edge
    s_next.ack = req & ~s_reg.ack;
    if (req & ~s_reg.ack) begin
      case (avm_i.address)
        ADR_DATA: s_next.rdata = {8'h0, top.d};
        ADR_IER: s_next.rdata = {8'h0, s_reg.interrupt_enable_reg};
        ADR_LCR: s_next.rdata = {8'h0, s_reg.line_format_control};
        ADR_MCR: s_next.rdata = {8'h0, s_reg.modem_pin_control};
        ADR_LSR: s_next.rdata = {8'h0, line_status_flags};
        ADR_MSR: s_next.rdata = {8'h0, modem_input_status};
        ADR_EFR: s_next.rdata = {8'h0, s_reg.enhanced_feature_reg};
        ADR_DIV: s_next.rdata = s_reg.div;
        default: s_next.rdata = 16'h0;
      endcase
    end
    if (acc & avm_i.read) begin
      if (avm_i.address == ADR_DATA) rpop = s_reg.rn != '0;
      if (avm_i.address == ADR_LSR) s_next.ovr = 1'b0;
    end
    if (acc & avm_i.write & avm_i.byteenable[0]) begin
      case (avm_i.address)
        ADR_DATA: begin
          // host must not touch other registers in between
          if (s_reg.modem_pin_control[MCR_IMM] & ~loop) begin
            s_next.modem_pin_control[MCR_IMM] = 1'b0;
            if (!s_reg.txdis) begin
              s_next.imm_v = 1'b1;
              s_next.imm = avm_i.writedata[7:0];
            end else begin
              tpush = s_reg.tn != FULL;
            end
          end else begin
            tpush = s_reg.tn != FULL;
          end
        end
        ADR_IER: s_next.interrupt_enable_reg = avm_i.writedata[7:0];
        ADR_LCR: s_next.line_format_control = avm_i.writedata[7:0];
        ADR_MCR: s_next.modem_pin_control = {s_reg.enhanced_feature_reg[EFR_ENH]
                               ? avm_i.writedata[7:5] : s_reg.modem_pin_control[7:5],
                               avm_i.writedata[4:0]};
        ADR_MSR: s_next.txdis = avm_i.writedata[MSR_TXDIS];
        ADR_EFR: s_next.enhanced_feature_reg = avm_i.writedata[7:0];
        ADR_DIV: s_next.div = {avm_i.byteenable[1]
                               ? avm_i.writedata[15:8] : s_reg.div[15:8],
                               avm_i.writedata[7:0]};
        default: ;
      endcase
    end

    // ===============================================================
    // baud tick
    s_next.pre = s_reg.modem_pin_control[MCR_PRE] ? s_reg.pre + 2'h1 : 2'h0;
    if (bclk) s_next.bcnt = tick ? 16'h0 : s_reg.bcnt + 16'h1;
    if (rx_i) s_next.irc = IR_HOLD;
    else if (tick && s_reg.irc != 4'h0) s_next.irc = s_reg.irc - 4'h1;

    // ===============================================================
    // transmitter
    if (tick) begin
      s_next.tt = s_reg.tt + 5'h1;
      unique case (s_reg.ts)
        TX_IDLE: begin
          s_next.tt = 5'h0;
          s_next.tline = 1'b1;
          // flow characters outrank the immediate byte
          if (s_reg.fl_v) begin
            tld = 1'b1;
            tbyte = s_reg.fl;
            s_next.fl_v = 1'b0;
          end else if (!s_reg.txdis && !hw_stop) begin
            if (s_reg.imm_v) begin
              tld = 1'b1;
              tbyte = s_reg.imm;
              s_next.imm_v = 1'b0;
            end else if (s_reg.tn != '0 && !s_reg.xoff_rx) begin
              tld = 1'b1;
              tpop = 1'b1;
              tbyte = s_reg.tq[s_reg.tr];
            end
          end
        end
        TX_START: if (s_reg.tt == BIT_LAST) begin
          s_next.tt = 5'h0;
          s_next.tb = 3'h0;
          s_next.ts = TX_DATA;
          s_next.tline = s_reg.tsh[0];
        end
        TX_DATA: if (s_reg.tt == BIT_LAST) begin
          s_next.tt = 5'h0;
          s_next.tsh = s_reg.tsh >> 1;
          s_next.tb = s_reg.tb + 3'h1;
          s_next.tline = s_reg.tsh[1];
          if (s_reg.tb == wlast) begin
            s_next.ts = s_reg.line_format_control[LCR_PEN] ? TX_PAR : TX_STOP;
            s_next.tline = s_reg.line_format_control[LCR_PEN] ? s_reg.tpar : 1'b1;
          end
        end
        TX_PAR: if (s_reg.tt == BIT_LAST) begin
          s_next.tt = 5'h0;
          s_next.ts = TX_STOP;
          s_next.tline = 1'b1;
        end
        TX_STOP: if (s_reg.tt == stop_last(s_reg.line_format_control)) begin
          s_next.ts = TX_IDLE;
        end
        default: s_next.ts = TX_IDLE;
      endcase
    end
    if (tld) begin
      s_next.tsh = tbyte;
      s_next.tdat = tbyte;
      s_next.tpar = par_bit(tbyte, s_reg.line_format_control);
      s_next.tline = 1'b0;
      s_next.ts = TX_START;
    end

    // ===============================================================
    // receiver; rt wraps every 16 ticks, so bit centres need no reload
    if (tick) begin
      s_next.rt = s_reg.rt + 4'h1;
      unique case (s_reg.rs)
        RX_IDLE: begin
          s_next.rt = 4'h0;
          if (rxd) s_next.brk_act = 1'b0;
          else if (!s_reg.brk_act) begin
            s_next.rs = RX_START;
            s_next.rz = 1'b1;
          end
        end
        RX_START: if (s_reg.rt == MID_LAST) begin
          s_next.rt = 4'h0;
          s_next.rb = 3'h0;
          s_next.rs = rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (s_reg.rt == RBIT_LAST) begin
          s_next.rsh = {rxd, s_reg.rsh[7:1]};
          s_next.rz = s_reg.rz & ~rxd;
          s_next.rb = s_reg.rb + 3'h1;
          if (s_reg.rb == wlast) begin
            s_next.rs = s_reg.line_format_control[LCR_PEN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (s_reg.rt == RBIT_LAST) begin
          s_next.rpar = rxd;
          s_next.rz = s_reg.rz & ~rxd;
          s_next.rs = RX_STOP;
        end
        RX_STOP: if (s_reg.rt == RBIT_LAST) begin
          s_next.rs = RX_IDLE;
          rdone = 1'b1;
        end
        default: s_next.rs = RX_IDLE;
      endcase
    end
    if (rdone) begin
      rent.d = rdat;
      rent.brk = s_reg.rz & ~rxd;
      rent.fe = ~rxd & ~rent.brk;
      rent.pe = s_reg.line_format_control[LCR_PEN] & ~rent.brk
                & (s_reg.rpar != par_bit(rdat, s_reg.line_format_control));
      if (rent.brk) s_next.brk_act = 1'b1;
      // overrun set comes after the status-read clear, so it wins
      if (s_reg.rn == FULL) s_next.ovr = 1'b1;
      else rpush = 1'b1;
      if (s_reg.enhanced_feature_reg[EFR_SWF] & ~rent.brk) begin
        if (rdat == XOFF_CHAR) s_next.xoff_rx = 1'b1;
        else if (s_reg.modem_pin_control[MCR_XANY] | (rdat == XON_CHAR))
          s_next.xoff_rx = 1'b0;
      end
    end
    // local flow characters throttle the far transmitter
    if (s_reg.enhanced_feature_reg[EFR_SWF] & ~s_reg.fl_v) begin
      if (!s_reg.xoff_sent && s_reg.rn >= HIGH) begin
        s_next.fl_v = 1'b1;
        s_next.fl = XOFF_CHAR;
        s_next.xoff_sent = 1'b1;
      end else if (s_reg.xoff_sent && s_reg.rn == '0) begin
        s_next.fl_v = 1'b1;
        s_next.fl = XON_CHAR;
        s_next.xoff_sent = 1'b0;
      end
    end

    // ===============================================================
    // queues
    if (tpush) begin
      s_next.tq[s_reg.tw] = avm_i.writedata[7:0];
      s_next.tw = s_reg.tw + 1'b1;
    end
    if (tpop) s_next.tr = s_reg.tr + 1'b1;
    s_next.tn = s_reg.tn + ulm_cnt_t'(tpush) - ulm_cnt_t'(tpop);
    if (rpush) begin
      s_next.rq[s_reg.rw] = rent;
      s_next.rw = s_reg.rw + 1'b1;
    end
    if (rpop) s_next.rr = s_reg.rr + 1'b1;
    s_next.rn = s_reg.rn + ulm_cnt_t'(rpush) - ulm_cnt_t'(rpop);
    s_next.errn = s_reg.errn
      + ulm_cnt_t'(rpush & (rent.brk | rent.fe | rent.pe))
      - ulm_cnt_t'(rpop & (top.brk | top.fe | top.pe));

    // ===============================================================
    // pins; loopback keeps the line and modem outputs idle
    if (s_next.modem_pin_control[MCR_LOOP]) s_next.txo = ~s_next.modem_pin_control[MCR_IR];
    else if (s_next.modem_pin_control[MCR_IR])
      s_next.txo = ~(s_next.tline & ~s_next.line_format_control[LCR_BRK])
                   & (s_next.tt < IR_PULSE);
    else s_next.txo = s_next.tline & ~s_next.line_format_control[LCR_BRK];
    s_next.rts_n = s_next.modem_pin_control[MCR_LOOP] | ((af & ~s_reg.modem_pin_control[MCR_SEL])
                   ? s_reg.rn >= HIGH : ~s_reg.modem_pin_control[MCR_RTS]);
    s_next.dtr_n = s_next.modem_pin_control[MCR_LOOP] | ((af & s_reg.modem_pin_control[MCR_SEL])
                   ? s_reg.rn >= HIGH : ~s_reg.modem_pin_control[MCR_DTR]);
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= '0;
      s_reg.div <= DIV_RST;
      s_reg.tline <= 1'b1;
      s_reg.txo <= 1'b1;
      s_reg.rts_n <= 1'b1;
      s_reg.dtr_n <= 1'b1;
      s_reg.line_format_control <= REG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // =================================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_first;
    req && !s_reg.ack;
  endsequence
  sequence s_stop_end;
    s_reg.ts == TX_STOP && tick && s_reg.tt == stop_last(s_reg.line_format_control);
  endsequence

  chk_bus_answer: assert property (s_first |=> !avm_o.waitrequest)
    else $error("bus answer late");
  chk_parity_sense: assert property (
    (s_reg.ts == TX_PAR && !s_reg.line_format_control[LCR_STICK]) |->
    ((^(s_reg.tdat & wmask(s_reg.line_format_control)) ^ s_reg.tpar) !=
     s_reg.line_format_control[LCR_EPS])) else $error("parity sense wrong");
  chk_parity_stick: assert property (
    (s_reg.ts == TX_PAR && s_reg.line_format_control[LCR_STICK]) |->
    s_reg.tpar == ~s_reg.line_format_control[LCR_EPS]) else $error("forced parity wrong");
  chk_no_parity: assert property (
    (s_reg.ts == TX_DATA && tick && s_reg.tt == BIT_LAST &&
     s_reg.tb == wlast && !s_reg.line_format_control[LCR_PEN] && !tld) |=>
    s_reg.ts == TX_STOP) else $error("parity bit not skipped");
  chk_stop_len: assert property (
    (s_reg.ts == TX_STOP && tick) |->
    s_reg.tt <= stop_last(s_reg.line_format_control)) else $error("stop too long");
  chk_stop_exit: assert property (s_stop_end |=>
    s_reg.ts != TX_STOP) else $error("stop not ended");
  chk_word_len: assert property (
    s_reg.ts == TX_DATA |-> s_reg.tb <= wlast)
    else $error("word too long");
  chk_prescale: assert property (
    (s_reg.modem_pin_control[MCR_PRE] && $past(s_reg.modem_pin_control[MCR_PRE]) && bclk) |->
    !$past(bclk)) else $error("prescale not applied");
  chk_strap_load: assert property (
    (s_reg.strap_done && !$past(s_reg.strap_done)) |->
    s_reg.modem_pin_control[MCR_IR] == $past(ir_strap_i)) else $error("strap lost");
  chk_loop_quiet: assert property (
    s_reg.modem_pin_control[MCR_LOOP] |-> (tx_o == ~s_reg.modem_pin_control[MCR_IR] &&
    modem_o.rts_n && modem_o.dtr_n)) else $error("loop pins active");
  chk_imm_clear: assert property (
    (acc && avm_i.write && avm_i.byteenable[0] &&
     avm_i.address == ADR_DATA && !loop) |=> !s_reg.modem_pin_control[MCR_IMM])
    else $error("immediate bit stuck");
  chk_line_irq: assert property (
    (s_reg.interrupt_enable_reg[IER_LS] && s_reg.errn != '0) |-> line_irq_o)
    else $error("line irq missing");
  chk_temt: assert property (line_status_flags[6] |-> (line_status_flags[5] &&
    s_reg.ts == TX_IDLE)) else $error("empty flag early");
  chk_overrun: assert property (
    (rdone && s_reg.rn == FULL && !rpop) |=>
    (s_reg.ovr && s_reg.rn == FULL)) else $error("overrun lost");
  chk_break_hold: assert property (
    (s_reg.brk_act && !rxd) |=> s_reg.brk_act)
    else $error("break dropped early");
  chk_ready: assert property (rpush |=> line_status_flags[0])
    else $error("ready missing");
endmodule : ulm_top
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the uart line, modem and status block
`timescale 1ns/1ns
`default_nettype none
module tb_top import ulm_pkg::*;;
  logic clk, rst_n, rx, tx, irq;
  ulm_avm_req_t req;
  ulm_avm_rsp_t rsp;
  ulm_modem_out_t mo;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rd_v;
  logic [15:0] got;
  logic [7:0] lcr_t[4] = '{8'h1b, 8'h2b, 8'h04, 8'h0a};
  logic [7:0] dat_t[4] = '{8'ha5, 8'h00, 8'h00, 8'h7f};
  int nb_t[4] = '{10, 10, 6, 9};
  logic [15:0] exp_t[4] = '{16'h2a5, 16'h300, 16'h020, 16'h17f};
  logic [15:0] rb_t[3] = '{16'h23c, 16'h33c, 16'h000};
  int rn_t[3] = '{10, 10, 12};
  logic [7:0] rl_t[3] = '{8'h61, 8'he5, 8'hf1};
  logic [7:0] rd_t[3] = '{8'h3c, 8'h3c, 8'h00};
  logic [15:0] imm_t[4] = '{16'h233, 16'h307, 16'h244, 16'h255};
  logic strap;
  ulm_modem_in_t mi;
  ulm_top #(.DEPTH(16)) ulm_top_inst (.core_clk_i(clk), .reset_n_i(rst_n),
    .avm_i(req), .avm_o(rsp), .rx_i(rx), .tx_o(tx),
    .modem_i(mi), .modem_o(mo), .ir_strap_i(strap),
    .line_irq_o(irq));
  ulm_remote ulm_remote_inst (.clk_i(clk), .line_i(tx), .line_o(rx));
  // ==========
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end
  // ==========
  // tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // request holds until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf,
             writedata: d};
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    rd_v = rsp.readdata;
    req <= '0;
  endtask : bus
  task automatic rdchk(input string nm, input logic [4:0] a,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd_v, exp);
  endtask : rdchk
  // ==========
  // main sequence
  initial begin
    req = '0;
    mi = 4'hf;
    strap = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("lcr_reset", ADR_LCR, 32'h0);
    rdchk("mcr_reset", ADR_MCR, 32'h0);
    rdchk("lsr_reset", ADR_LSR, 32'h60);
    chk("pins_reset", 32'(mo), 32'h3);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADR_MCR, 32'(i));
      repeat (2) @(posedge clk);
      chk("modem_pins", 32'(mo), 32'(~i[1:0] & 2'h3));
    end
    bus(1'b1, ADR_MCR, 32'h0);
    // one frame per format: parity kinds, word length, stop length
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADR_LCR, 32'(lcr_t[i]));
      fork
        ulm_remote_inst.grab(nb_t[i], got);
        begin
          bus(1'b1, ADR_DATA, 32'(dat_t[i]));
          bus(1'b0, ADR_LSR, 32'h0);
          chk("temt_busy", 32'(rd_v[6]), 32'h0);
        end
      join
      chk("tx_frame", 32'(got), 32'(exp_t[i]));
      do bus(1'b0, ADR_LSR, 32'h0); while (rd_v[6] !== 1'b1);
      chk("lsr_idle", rd_v, 32'h60);
    end
    // good frame, parity error, then a break
    bus(1'b1, ADR_LCR, 32'h1b);
    bus(1'b1, ADR_IER, 32'h04);
    for (int i = 0; i < 3; i++) begin
      ulm_remote_inst.send(rb_t[i], rn_t[i]);
      repeat (16) @(posedge clk);
      rdchk("lsr_rx", ADR_LSR, 32'(rl_t[i]));
      chk("irq_rx", 32'(irq), 32'(rl_t[i][7]));
      rdchk("rx_data", ADR_DATA, 32'(rd_t[i]));
      rdchk("lsr_drained", ADR_LSR, 32'h60);
    end
    // loopback: legacy outputs on status, data returns internally
    bus(1'b1, ADR_MCR, 32'h1c);
    rdchk("msr_loop", ADR_MSR, 32'hc0);
    bus(1'b1, ADR_MCR, 32'h10);
    bus(1'b1, ADR_DATA, 32'h5a);
    repeat (40) @(posedge clk);
    chk("loop_tx", 32'(tx), 32'h1);
    do bus(1'b0, ADR_LSR, 32'h0); while (rd_v[0] !== 1'b1);
    rdchk("loop_data", ADR_DATA, 32'h5a);
    bus(1'b1, ADR_MCR, 32'h0);
    // send-immediate byte overtakes the two queued bytes
    fork
      for (int k = 0; k < 4; k++) begin
        ulm_remote_inst.grab(10, got);
        chk("imm_order", 32'(got), 32'(imm_t[k]));
      end
      begin
        bus(1'b1, ADR_DATA, 32'h33);
        bus(1'b1, ADR_DATA, 32'h44);
        bus(1'b1, ADR_DATA, 32'h55);
        bus(1'b1, ADR_MCR, 32'h08);
        bus(1'b1, ADR_DATA, 32'h07);
        rdchk("imm_clear", ADR_MCR, 32'h0);
      end
    join
    do bus(1'b0, ADR_LSR, 32'h0); while (rd_v[6] !== 1'b1);
    // auto flow on the rts/cts pair holds the byte while cts_n is high
    bus(1'b1, ADR_EFR, 32'h40);
    bus(1'b1, ADR_DATA, 32'h3c);
    repeat (40) @(posedge clk);
    chk("auto_pins", 32'(mo), 32'h1);
    rdchk("lsr_held", ADR_LSR, 32'h0);
    mi <= 4'h7;
    do bus(1'b0, ADR_LSR, 32'h0); while (rd_v[6] !== 1'b1);
    chk("lsr_sent", rd_v, 32'h60);
    bus(1'b1, ADR_MCR, 32'h04);
    repeat (2) @(posedge clk);
    chk("auto_dtr", 32'(mo), 32'h2);
    // prescaler bit is locked until the enhanced bit is set
    bus(1'b1, ADR_EFR, 32'h0);
    bus(1'b1, ADR_MCR, 32'h80);
    rdchk("pre_locked", ADR_MCR, 32'h0);
    bus(1'b1, ADR_EFR, 32'h10);
    bus(1'b1, ADR_MCR, 32'h80);
    rdchk("pre_set", ADR_MCR, 32'h80);
    // second reset with the infrared strap high
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("mcr_strap", ADR_MCR, 32'h40);
    chk("ir_idle", 32'(tx), 32'h0);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire

//--- tb/ulm_remote.sv
// remote serial device model for the uart channel
`timescale 1ns/1ns
`default_nettype none
module ulm_remote (
  input wire logic clk_i,
  input wire logic line_i,
  output var logic line_o
);
  // ==========
  // line idles at mark; 16 clocks a bit since the divisor stays at 1
  initial line_o = 1'b1;
  task automatic send(input logic [15:0] b, input int n);
    line_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= b[i];
      repeat (16) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask : send
  // samples mid-bit, so a short stop still reads as one bit
  task automatic grab(input int n, output logic [15:0] b);
    b = '0;
    do @(posedge clk_i); while (line_i !== 1'b0);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(posedge clk_i);
      b[i] = line_i;
    end
  endtask : grab
endmodule : ulm_remote
`default_nettype wire
